// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"
module tb;
  import tcc_pkg::*;
  logic clk_sys_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err_q;
  logic ext_count_pin_in, global_irq_enable_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd_q;
  logic [2:0] irq_ack_in, irq_req_out;
  logic [7:0] counter_value_out, v;
  tcc_mode_t mode_out;
  int n_mismatch, samples_checked;
  tcc_timer8 u_dut (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .ext_count_pin_in(ext_count_pin_in),
    .global_irq_enable_in(global_irq_enable_in),
    .irq_ack_in(irq_ack_in),
    .irq_req_out(irq_req_out),
    .counter_value_out(counter_value_out),
    .mode_out(mode_out)
  );
  tcc_pin_model u_pin (.clk_in(clk_sys_in), .pin_out(ext_count_pin_in));
  // ====
  // checks and bus
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    // no wait-state count is assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_sys_in);
    end while (pready_out !== 1'b1);
    rd_q = prdata_out;
    err_q = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  // the source stays selected from the control commit to the stop commit:
  // the 1024 waited edges plus three bus edges
  localparam int div_win = 1027;
  // fewest ticks in that window, modulo the 8-bit counter; the phase may add one
  function automatic logic [7:0] exp_div(input int k);
    int sh;
    sh = (k == 1) ? 0 : (k == 2) ? 3 : (k == 3) ? 6 : (k == 4) ? 8 : 10;
    return 8'(div_win >> sh);
  endfunction
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ====
  // clock, watchdog and tests
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #600000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {rst_n_in, psel_in, penable_in, pwrite_in, global_irq_enable_in} = 5'h00;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    irq_ack_in = 3'b000;
    v = 8'($urandom(67));
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    for (int i = 0; i < 6; i++) rd_chk(12'(i * 4), 32'h0);
    rd_chk(12'h018, 32'h0);
    chk(err_q, 1'b1);
    apb(1'b1, `TCC_ADDR_CTRL, 32'hff);
    rd_chk(`TCC_ADDR_CTRL, 32'h0f);
    apb(1'b1, `TCC_ADDR_MASK, 32'hff);
    rd_chk(`TCC_ADDR_MASK, 32'h07);
    apb(1'b1, `TCC_ADDR_CTRL, 32'h0);
    for (int i = 2; i < 4; i++) begin
      v = 8'($urandom);
      apb(1'b1, 12'(i * 4), v);
      rd_chk(12'(i * 4), v);
    end
    // a counter write hides the match on the next tick only
    v = 8'($urandom % 200) + 8'h08;
    apb(1'b1, `TCC_ADDR_CMPA, 32'hff);
    apb(1'b1, `TCC_ADDR_CMPB, v);
    apb(1'b1, `TCC_ADDR_COUNT, v);
    apb(1'b1, `TCC_ADDR_CTRL, 32'h7);
    u_pin.pulses(1);
    rd_chk(`TCC_ADDR_FLAGS, 32'h0);
    rd_chk(`TCC_ADDR_COUNT, v + 8'h01);
    apb(1'b1, `TCC_ADDR_CMPB, v + 8'h01);
    rd_chk(`TCC_ADDR_FLAGS, 32'h0);
    u_pin.pulses(1);
    rd_chk(`TCC_ADDR_FLAGS, 32'h4);
    global_irq_enable_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    chk({29'h0, irq_req_out}, 32'h4);
    apb(1'b1, `TCC_ADDR_FLAGS, 32'h0);
    rd_chk(`TCC_ADDR_FLAGS, 32'h4);
    irq_ack_in <= 3'b100;
    @(posedge clk_sys_in);
    irq_ack_in <= 3'b000;
    rd_chk(`TCC_ADDR_FLAGS, 32'h0);
    chk({29'h0, irq_req_out}, 32'h0);
    // clear-on-match period, then a top written below the count
    apb(1'b1, `TCC_ADDR_CMPA, 32'h3);
    apb(1'b1, `TCC_ADDR_CMPB, 32'h0);
    apb(1'b1, `TCC_ADDR_COUNT, 32'h0);
    apb(1'b1, `TCC_ADDR_CTRL, 32'hf);
    u_pin.pulses(4);
    rd_chk(`TCC_ADDR_COUNT, 32'h0);
    rd_chk(`TCC_ADDR_FLAGS, 32'h2);
    apb(1'b1, `TCC_ADDR_FLAGS, 32'h7);
    apb(1'b1, `TCC_ADDR_COUNT, 32'h5);
    apb(1'b1, `TCC_ADDR_CMPA, 32'h2);
    u_pin.pulses(251);
    rd_chk(`TCC_ADDR_COUNT, 32'h0);
    rd_chk(`TCC_ADDR_FLAGS, 32'h1);
    for (int k = 1; k < 6; k++) begin
      apb(1'b1, `TCC_ADDR_COUNT, 32'h0);
      apb(1'b1, `TCC_ADDR_CTRL, k);
      repeat (1024) @(posedge clk_sys_in);
      apb(1'b1, `TCC_ADDR_CTRL, 32'h0);
      apb(1'b0, `TCC_ADDR_COUNT, 32'h0);
      chk(8'(rd_q[7:0] - exp_div(k)) <= 8'h01, 1'b1);
    end
    v = 8'($urandom % 20) + 8'h01;
    apb(1'b1, `TCC_ADDR_COUNT, 32'h0);
    apb(1'b1, `TCC_ADDR_CTRL, 32'h6);
    u_pin.pulses(v);
    rd_chk(`TCC_ADDR_COUNT, v);
    final_report();
  end
endmodule
bind tcc_timer8 tcc_timer8_asserts u_chk (
  .clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .prdata_out(prdata_out),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .global_irq_enable_in(global_irq_enable_in),
  .irq_req_out(irq_req_out),
  .counter_value_out(counter_value_out),
  .mode_out(mode_out)
);
`default_nettype wire

// ==== tcc_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  input wire logic clk_in,
  output logic pin_out
);
  initial pin_out = 1'b0;
  // pin driven as an output by software still has to count
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_in) pin_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      pin_out <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ==== tcc_pkg.sv ====
package tcc_pkg;
  typedef enum logic [2:0] {
    TCC_SRC_STOP, TCC_SRC_CLK, TCC_SRC_DIV8, TCC_SRC_DIV64,
    TCC_SRC_DIV256, TCC_SRC_DIV1024, TCC_SRC_PIN_FALL, TCC_SRC_PIN_RISE
  } tcc_src_t;
  typedef enum logic {TCC_MODE_NORMAL, TCC_MODE_CLEAR} tcc_mode_t;
endpackage

// ==== tcc_regs.svh ====
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
// Notes on behaviour
// RL1 - mode bit 1: count on tick, clear to zero when counter matches compare A
// RL2 - compare A below count is missed; counter runs to 0xff, wraps, then matches
// RL3 - in clear-on-match mode wrap flag sets on the tick going 0xff to 0x00
// RL4 - in clear-on-match mode match flag A sets each time counter reaches top
// RL5 - compare writes take effect at once, no double buffering
// RL6 - control bit 3 picks normal (top 0xff) or clear-on-match (top compare A)
// RL7 - control bits 7:4, mask and flag bits 7:3 read zero
// RL8 - source codes: 000 stop, 001 clock, 010-101 divide by 8,64,256,1024
// RL9 - code 110 counts falling pin edges, code 111 rising pin edges
// RL10 - pin edges count even when the pin is driven as an output
// RL11 - counter readable and writable; a write blocks matches on the next tick
// RL12 - two 8-bit compare values compared continuously with the counter
// RL13 - mask bits 2,1,0 enable B, A, wrap; request needs mask, global and flag
// RL14 - flag bit 2 match B, bit 1 match A, bit 0 overflow
// RL15 - each flag clears on its per-source acknowledge input
// RL16 - writing one to a flag bit clears it, zero leaves it
// RL17 - fully synchronous; tick is a one-cycle clock enable
// RL18 - software counter write beats clear or increment in the same cycle
// RL19 - equality sets the match flag at the next tick, not at once
// RL20 - normal mode counts up only, wraps 0xff to 0x00 setting wrap flag
// RL21 - hardware set beats software clear on the same flag in the same cycle
// RL22 - reset clears every control, counter, compare, mask and flag bit

// register byte addresses on the apb bus
`define TCC_ADDR_CTRL 12'h000
`define TCC_ADDR_COUNT 12'h004
`define TCC_ADDR_CMPA 12'h008
`define TCC_ADDR_CMPB 12'h00c
`define TCC_ADDR_MASK 12'h010
`define TCC_ADDR_FLAGS 12'h014
// field positions and byte values
`define TCC_CTRL_MODE_BIT 3
`define TCC_FLAG_B_BIT 2
`define TCC_FLAG_A_BIT 1
`define TCC_FLAG_WRAP_BIT 0
`define TCC_RST_BYTE 8'h00
`define TCC_MAX 8'hff
`define TCC_ZERO 8'h00
// prescaler divide-by-n terminal counts (n minus one)
`define TCC_DIV8_TC 10'h007
`define TCC_DIV64_TC 10'h03f
`define TCC_DIV256_TC 10'h0ff
`define TCC_DIV1024_TC 10'h3ff
`endif

// ==== tcc_timer8.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"
module tcc_timer8 (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // external count pin and processor status
  input wire logic ext_count_pin_in,
  input wire logic global_irq_enable_in,
  // per-source acknowledge: bit 2 match b, bit 1 match a, bit 0 wrap
  input wire logic [2:0] irq_ack_in,
  // interrupt requests: bit 2 match b, bit 1 match a, bit 0 wrap
  output logic [2:0] irq_req_out,
  output logic [7:0] counter_value_out,
  output tcc_pkg::tcc_mode_t mode_out
);
  import tcc_pkg::*;

  // ==========================================================
  // register state
  logic [7:0] counter_value_r;
  logic [7:0] compare_a_r;
  logic [7:0] compare_b_r;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_flags_r;
  tcc_src_t source_select_r;
  tcc_mode_t clear_on_match_select_r;
  logic [9:0] prescale_r;
  logic pin_last_r;
  logic block_match_r;

  logic setup_wr, access;
  logic wr_ctrl, wr_count, wr_cmpa, wr_cmpb, wr_mask, wr_flags;
  logic addr_ok;

  // one-cycle access phase: the slave answers in the first access cycle
  assign access = psel_in & penable_in;
  assign setup_wr = access & pwrite_in;
  assign wr_ctrl = setup_wr & (paddr_in == `TCC_ADDR_CTRL);
  assign wr_count = setup_wr & (paddr_in == `TCC_ADDR_COUNT);
  assign wr_cmpa = setup_wr & (paddr_in == `TCC_ADDR_CMPA);
  assign wr_cmpb = setup_wr & (paddr_in == `TCC_ADDR_CMPB);
  assign wr_mask = setup_wr & (paddr_in == `TCC_ADDR_MASK);
  assign wr_flags = setup_wr & (paddr_in == `TCC_ADDR_FLAGS);
  assign addr_ok = (paddr_in == `TCC_ADDR_CTRL) | (paddr_in == `TCC_ADDR_COUNT) |
                   (paddr_in == `TCC_ADDR_CMPA) | (paddr_in == `TCC_ADDR_CMPB) |
                   (paddr_in == `TCC_ADDR_MASK) | (paddr_in == `TCC_ADDR_FLAGS);

  // ==========================================================
  // clock source select and prescaler
  logic tick;
  logic pin_rise, pin_fall;
  // the pin is sampled as-is, so software driving it as an output still counts
  assign pin_rise = ext_count_pin_in & ~pin_last_r; // see RL10
  assign pin_fall = ~ext_count_pin_in & pin_last_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      prescale_r <= 10'h000;
      pin_last_r <= 1'b0;
    end else begin
      prescale_r <= prescale_r + 10'h001;
      pin_last_r <= ext_count_pin_in;
    end
  end

  always_comb begin
    case (source_select_r) // see RL8
      TCC_SRC_STOP: tick = 1'b0;
      TCC_SRC_CLK: tick = 1'b1;
      // the prescaler wraps at 1024, so each tap fires when its low bits are all ones
      TCC_SRC_DIV8: tick = ((prescale_r & `TCC_DIV8_TC) == `TCC_DIV8_TC);
      TCC_SRC_DIV64: tick = ((prescale_r & `TCC_DIV64_TC) == `TCC_DIV64_TC);
      TCC_SRC_DIV256: tick = ((prescale_r & `TCC_DIV256_TC) == `TCC_DIV256_TC);
      TCC_SRC_DIV1024: tick = ((prescale_r & `TCC_DIV1024_TC) == `TCC_DIV1024_TC);
      TCC_SRC_PIN_FALL: tick = pin_fall; // see RL9
      TCC_SRC_PIN_RISE: tick = pin_rise; // see RL9
      default: tick = 1'b0;
    endcase
  end

  // ==========================================================
  // counter unit
  logic match_a, match_b, at_top, wrap_evt, set_a, set_b;
  assign match_a = (counter_value_r == compare_a_r); // see RL12
  assign match_b = (counter_value_r == compare_b_r); // see RL12
  // compare registers are read live, so a new top applies at once
  assign at_top = (clear_on_match_select_r == TCC_MODE_CLEAR) ? match_a // see RL5
                  : (counter_value_r == `TCC_MAX); // see RL6
  // wrap flag sets only going max to zero, in both modes
  assign wrap_evt = tick & (counter_value_r == `TCC_MAX); // see RL3
  // flags set on the tick after the equality, unless a counter write blocked it
  assign set_a = tick & match_a & ~block_match_r; // see RL19
  assign set_b = tick & match_b & ~block_match_r; // see RL11

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      counter_value_r <= `TCC_RST_BYTE; // see RL22
    end else if (wr_count) begin
      counter_value_r <= pwdata_in[7:0]; // see RL18
    end else if (tick) begin // see RL17
      // a top below the count is missed and the counter rolls past 0xff
      if (at_top || counter_value_r == `TCC_MAX) begin // see RL2
        counter_value_r <= `TCC_ZERO; // see RL1
      end else begin
        counter_value_r <= counter_value_r + 8'h01; // see RL20
      end
    end
  end

  // blocking holds until the next tick, even while stopped
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      block_match_r <= 1'b0;
    end else if (wr_count) begin
      block_match_r <= 1'b1; // see RL11
    end else if (tick) begin
      block_match_r <= 1'b0;
    end
  end

  // ==========================================================
  // control, compare and mask registers
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      source_select_r <= TCC_SRC_STOP; // see RL22
      clear_on_match_select_r <= TCC_MODE_NORMAL;
      compare_a_r <= `TCC_RST_BYTE;
      compare_b_r <= `TCC_RST_BYTE;
      irq_mask_r <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        source_select_r <= tcc_src_t'(pwdata_in[2:0]); // see RL6
        clear_on_match_select_r <= tcc_mode_t'(pwdata_in[`TCC_CTRL_MODE_BIT]);
      end
      if (wr_cmpa) begin
        compare_a_r <= pwdata_in[7:0]; // see RL5
      end
      if (wr_cmpb) begin
        compare_b_r <= pwdata_in[7:0];
      end
      if (wr_mask) begin
        irq_mask_r <= pwdata_in[2:0];
      end
    end
  end

  // ==========================================================
  // flags: one generate entry per source
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  assign flag_set = {set_b, set_a, wrap_evt}; // see RL14 see RL4
  assign flag_clr = irq_ack_in | ({3{wr_flags}} & pwdata_in[2:0]); // see RL15 see RL16

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
      always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
          irq_flags_r[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          irq_flags_r[gi] <= 1'b1; // see RL21
        end else if (flag_clr[gi]) begin
          irq_flags_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // outputs, all registered
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      irq_req_out <= 3'h0;
      counter_value_out <= `TCC_RST_BYTE;
      mode_out <= TCC_MODE_NORMAL;
    end else begin
      irq_req_out <= irq_flags_r & irq_mask_r & {3{global_irq_enable_in}}; // see RL13
      counter_value_out <= counter_value_r;
      mode_out <= clear_on_match_select_r;
    end
  end

  // apb answer: pready pulses in the first access cycle; reads are registered
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~addr_ok;
      prdata_out <= 32'h0000_0000;
      if (psel_in && !penable_in && !pwrite_in) begin
        case (paddr_in)
          `TCC_ADDR_CTRL: begin
            prdata_out <= {28'h0, clear_on_match_select_r, source_select_r}; // see RL7
          end
          `TCC_ADDR_COUNT: prdata_out <= {24'h0, counter_value_r};
          `TCC_ADDR_CMPA: prdata_out <= {24'h0, compare_a_r};
          `TCC_ADDR_CMPB: prdata_out <= {24'h0, compare_b_r};
          `TCC_ADDR_MASK: prdata_out <= {29'h0, irq_mask_r}; // see RL7
          `TCC_ADDR_FLAGS: prdata_out <= {29'h0, irq_flags_r}; // see RL7
          default: prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== tcc_timer8_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"
module tcc_timer8_asserts (
  // clock, reset and bus
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // timer side
  input wire logic global_irq_enable_in,
  input wire logic [2:0] irq_req_out,
  input wire logic [7:0] counter_value_out,
  input wire tcc_pkg::tcc_mode_t mode_out
);
  import tcc_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  wire logic acc = psel_in && penable_in && pready_out;
  wire logic rd = acc && !pwrite_in;
  wire logic cnt_wr = acc && pwrite_in && paddr_in == `TCC_ADDR_COUNT;
  wire logic ctl_wr = acc && pwrite_in && paddr_in == `TCC_ADDR_CTRL;
  chk_ready_next: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access cycle");
  chk_ready_once: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  chk_err_unmapped: assert property (
    pready_out && paddr_in > 12'h014 |-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
    else $error("unmapped access not refused");
  chk_ctrl_rsvd: assert property (
    rd && paddr_in == `TCC_ADDR_CTRL |-> prdata_out[31:4] == 28'h0)
    else $error("control upper bits not zero");
  chk_flag_rsvd: assert property (
    rd && paddr_in inside {`TCC_ADDR_MASK, `TCC_ADDR_FLAGS} |-> prdata_out[31:3] == 29'h0)
    else $error("mask or flag upper bits not zero");
  chk_cnt_write: assert property (
    cnt_wr |-> ##2 counter_value_out == $past(pwdata_in[7:0], 2))
    else $error("counter write lost");
  chk_cnt_step: assert property (
    $changed(counter_value_out) && !$past(cnt_wr, 2) |->
    counter_value_out == $past(counter_value_out) + 8'h01 || counter_value_out == 8'h00)
    else $error("counter moved other than up or clear");
  chk_mode_ctrl: assert property (
    ctl_wr |-> ##2 mode_out == tcc_mode_t'($past(pwdata_in[3], 2)))
    else $error("mode does not follow control bit");
  chk_req_global: assert property (
    !$past(global_irq_enable_in) |-> irq_req_out == 3'b000)
    else $error("request without global enable");
  cov_wrap: cover property (counter_value_out == 8'h00 && $past(counter_value_out) == 8'hff);
  cov_req: cover property (irq_req_out != 3'b000);
  cov_err: cover property (pslverr_out);
endmodule
`default_nettype wire
